// ---- src/ttc_count_chan.sv ----
// Sixteen-bit down counter with dual-byte mode and recycle
`timescale 1ns/1ns
module ttc_count_chan
	import ttc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic tick,
	input wire logic byteMode,
	input wire logic [15:0] latchVal,
	output logic [15:0] count_q,
	output logic timeOut
);
	// Time-out is the tick that finds the counter at zero
	assign timeOut = tick & ~load & (count_q == '0);

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			count_q <= LATCH_MAX;
		else if (load)
			count_q <= latchVal;
		else if (tick)
		begin
			if (count_q == '0)
				count_q <= latchVal;
			else if (byteMode && count_q[7:0] == BYTE_ZERO)
				count_q <= {count_q[15:8] - 8'h01, latchVal[7:0]};
			else if (byteMode)
				count_q <= {count_q[15:8], count_q[7:0] - 8'h01};
			else
				count_q <= count_q - 16'h0001;
		end
	end
endmodule : ttc_count_chan

// ---- src/ttc_pkg.sv ----
// Constants shared by the triple timer control and status logic
package ttc_pkg;
	localparam int TIMERS = 3;
	// Register select codes
	localparam logic [2:0] RS_CTRL13 = 3'h0;
	localparam logic [2:0] RS_CTRL2_STATUS = 3'h1;
	localparam int RS_ODD_POS = 0;
	// Common control bit positions
	localparam int BIT_UNIQUE = 0;
	localparam int BIT_CLOCK_SOURCE = 1;
	localparam int BIT_BYTE_MODE = 2;
	localparam int BIT_MEASURE_MODE = 3;
	localparam int BIT_INIT_SELECT = 4;
	localparam int BIT_ONESHOT_POLARITY = 5;
	localparam int BIT_IRQ_MASK = 6;
	localparam int BIT_OUT_ENABLE = 7;
	localparam int STATUS_COMPOSITE_POS = 7;
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL1_RESET = 8'h01;
	localparam logic [15:0] LATCH_MAX = 16'hffff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] STATUS_UNUSED = 4'h0;
	// Divide-by-eight prescaler on timer three
	localparam logic [2:0] PRESCALE_LAST = 3'h7;
	localparam logic [2:0] PRESCALE_START = 3'h0;
	localparam int PRESCALED_TIMER = 2;
endpackage : ttc_pkg

// ---- src/ttc_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module ttc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_q;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			stage1_q <= '0;
			syncOut <= '0;
		end
		else
		begin
			stage1_q <= asyncIn;
			syncOut <= stage1_q;
		end
	end
endmodule : ttc_sync

// ---- src/ttc_timer_ctrl.sv ----
// Three-channel timer: bus registers, flags, counter control
// Operation
// - bit0 unique per register, bits1-7 per-timer
// - bit1 picks internal or external clock
// - word mode times out after N+1 ticks
// - byte mode times out after (L+1)(M+1)
// - bit6 masks interrupt, bit7 enables output
// - status read-only, bits three-six read zero
// - bits0-2 flags, bit7 masked composite
// - any timer reset clears every flag
// - counter read clears only status-seen flags
// - latch write or init clears own flag
// - one high-byte holding register, three addresses
// - latch write merges holding byte and data
// - external reset loads latches with maximum
// - internal reset leaves latches untouched
// - init copies latch, clears flag, on resets
// - gate fall or reset inits; latch if bits3-4=0
// - bits3-5 select the four operating modes
// - pulse-width bit5 picks shorter or longer
// - tick at zero reloads counter from latch
// - code 000 write banks on control two bit0
// - even codes holding/high, odd latch/low
// - internal reset presets, stops, clears outputs
// - control three bit0 adds divide-by-eight
`timescale 1ns/1ns
module ttc_timer_ctrl
	import ttc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic busEnable,
	input wire logic chipSelect0N,
	input wire logic chipSelect1,
	input wire logic readNotWrite,
	input wire logic [2:0] regSelect,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOeN,
	input wire logic irqIn,
	output logic irqOut,
	output logic irqOeN,
	input wire logic extResetN,
	input wire logic [2:0] clockPin,
	input wire logic [2:0] gatePin,
	output logic [2:0] timerOut
);
	// Timer index addressed by an even/odd code pair
	function automatic logic [1:0] timerOf(input logic [2:0] rs);
		timerOf = rs[2:1] - 2'h1;
	endfunction : timerOf

	// True for codes 010 through 111
	function automatic logic isTimerCode(input logic [2:0] rs);
		isTimerCode = (rs[2:1] != 2'h0);
	endfunction : isTimerCode

	logic resetS;
	logic [2:0] clockS;
	logic [2:0] gateS;
	logic [2:0] clockPrev_q;
	logic [2:0] gatePrev_q;
	logic [2:0] clockFall;
	logic [2:0] gateFall;
	logic [2:0] gateRise;
	logic hardReset;
	logic internalResetBit;
	logic [7:0] ctrl_q [TIMERS];
	logic [15:0] latch_q [TIMERS];
	logic [15:0] latch_d [TIMERS];
	logic [15:0] count_q [TIMERS];
	logic [7:0] holdByte_q;
	logic [7:0] lsbBuffer_q;
	logic [2:0] flag_q;
	logic [2:0] flag_d;
	logic [2:0] statusThenCounterRead_q;
	logic [2:0] timedOutSinceInit_q;
	logic [2:0] out_q;
	logic [2:0] prescale_q;
	logic access;
	logic wr;
	logic rd;
	logic [1:0] tmr;
	logic ctrlWr1;
	logic ctrlWr2;
	logic ctrlWr3;
	logic holdWr;
	logic statusRd;
	logic [2:0] latchWr;
	logic [2:0] counterRd;
	logic [2:0] counterLoadEvent;
	logic [2:0] tick;
	logic [2:0] timeOut;
	logic [2:0] srcTick;
	logic composite;
	logic [7:0] statusByte;

	ttc_sync #(.WIDTH(7)) uSync (
		.clock(clock),
		.sys_rst(sys_rst),
		.asyncIn({extResetN, gatePin, clockPin}),
		.syncOut({resetS, gateS, clockS})
	);

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			clockPrev_q <= '0;
			gatePrev_q <= '0;
		end
		else
		begin
			clockPrev_q <= clockS;
			gatePrev_q <= gateS;
		end
	end

	assign clockFall = clockPrev_q & ~clockS;
	assign gateFall = gatePrev_q & ~gateS;
	assign gateRise = ~gatePrev_q & gateS;
	assign hardReset = sys_rst | ~resetS;
	assign internalResetBit = ctrl_q[0][BIT_UNIQUE];

	// Bus decode
	assign access = busEnable & ~chipSelect0N & chipSelect1;
	assign wr = access & ~readNotWrite;
	assign rd = access & readNotWrite;
	assign tmr = timerOf(regSelect);
	assign ctrlWr1 = wr && regSelect == RS_CTRL13 && ctrl_q[1][BIT_UNIQUE];
	assign ctrlWr3 = wr && regSelect == RS_CTRL13 && !ctrl_q[1][BIT_UNIQUE];
	assign ctrlWr2 = wr && regSelect == RS_CTRL2_STATUS;
	assign holdWr = wr && !regSelect[RS_ODD_POS] && isTimerCode(regSelect);
	assign statusRd = rd && regSelect == RS_CTRL2_STATUS;

	always_comb
	begin
		for (int i = 0; i < TIMERS; i++)
		begin
			latchWr[i] = wr && regSelect[RS_ODD_POS] && isTimerCode(regSelect)
				&& tmr == 2'(i);
			counterRd[i] = rd && !regSelect[RS_ODD_POS] && isTimerCode(regSelect)
				&& tmr == 2'(i);
		end
	end

	// Control registers
	always_ff @(posedge clock)
	begin
		if (hardReset)
		begin
			ctrl_q[0] <= CTRL1_RESET;
			ctrl_q[1] <= CTRL_RESET;
			ctrl_q[2] <= CTRL_RESET;
		end
		else
		begin
			if (ctrlWr1)
				ctrl_q[0] <= dataIn;
			if (ctrlWr2)
				ctrl_q[1] <= dataIn;
			if (ctrlWr3)
				ctrl_q[2] <= dataIn;
		end
	end

	// Holding register and latches
	always_ff @(posedge clock)
	begin
		if (hardReset)
			holdByte_q <= BYTE_ZERO;
		else if (holdWr)
			holdByte_q <= dataIn;
	end

	always_comb
	begin
		for (int i = 0; i < TIMERS; i++)
		begin
			if (hardReset)
				latch_d[i] = LATCH_MAX;
			else if (latchWr[i])
				latch_d[i] = {holdByte_q, dataIn};
			else
				latch_d[i] = latch_q[i];
		end
	end

	always_ff @(posedge clock)
	begin
		for (int i = 0; i < TIMERS; i++)
			latch_q[i] <= latch_d[i];
	end

	// Per-timer clocking, prescaler and counter load
	always_comb
	begin
		for (int i = 0; i < TIMERS; i++)
		begin
			srcTick[i] = ctrl_q[i][BIT_CLOCK_SOURCE] ? 1'b1 : clockFall[i];
			if (i == PRESCALED_TIMER && ctrl_q[i][BIT_UNIQUE])
				srcTick[i] = srcTick[i] && prescale_q == PRESCALE_LAST;
			tick[i] = srcTick[i] & ~gateS[i] & ~hardReset & ~internalResetBit;
			counterLoadEvent[i] = hardReset | internalResetBit | gateFall[i]
				| (latchWr[i] & ~ctrl_q[i][BIT_INIT_SELECT]
				& ~ctrl_q[i][BIT_MEASURE_MODE]);
		end
	end

	always_ff @(posedge clock)
	begin
		if (hardReset || internalResetBit || !ctrl_q[PRESCALED_TIMER][BIT_UNIQUE])
			prescale_q <= PRESCALE_START;
		else if (ctrl_q[PRESCALED_TIMER][BIT_CLOCK_SOURCE] || clockFall[PRESCALED_TIMER])
			prescale_q <= prescale_q + 3'h1;
	end

	genvar g;
	generate
		for (g = 0; g < TIMERS; g++)
		begin : gChan
			ttc_count_chan uChan (
				.clock(clock),
				.sys_rst(sys_rst),
				.load(counterLoadEvent[g]),
				.tick(tick[g]),
				.byteMode(ctrl_q[g][BIT_BYTE_MODE]),
				.latchVal(latch_d[g]),
				.count_q(count_q[g]),
				.timeOut(timeOut[g])
			);
		end
	endgenerate

	// Flag set and clear; a set in the clearing cycle wins
	always_comb
	begin
		for (int i = 0; i < TIMERS; i++)
		begin
			logic setF;
			logic clrF;
			logic pol;
			setF = 1'b0;
			clrF = 1'b0;
			pol = ctrl_q[i][BIT_ONESHOT_POLARITY];
			if (!ctrl_q[i][BIT_MEASURE_MODE])
				setF = timeOut[i];
			else if (!ctrl_q[i][BIT_INIT_SELECT])
				setF = gateFall[i] && (pol ? timedOutSinceInit_q[i]
					: !timedOutSinceInit_q[i]);
			else if (pol)
				setF = timeOut[i] && !gateS[i];
			else
				setF = gateRise[i] && !timedOutSinceInit_q[i];
			setF = setF & ~hardReset & ~internalResetBit;
			clrF = counterLoadEvent[i] | latchWr[i]
				| (counterRd[i] & statusThenCounterRead_q[i]);
			flag_d[i] = setF | (flag_q[i] & ~clrF);
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			flag_q <= '0;
		else
			flag_q <= flag_d;
	end

	// Status seen while set arms the counter-read clear
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			statusThenCounterRead_q <= '0;
		else
			statusThenCounterRead_q <= ({3{statusRd}} & flag_q)
				| (statusThenCounterRead_q & flag_d);
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			timedOutSinceInit_q <= '0;
		else
			timedOutSinceInit_q <= timeOut | (timedOutSinceInit_q & ~counterLoadEvent);
	end

	// Timer outputs
	always_ff @(posedge clock)
	begin
		for (int i = 0; i < TIMERS; i++)
		begin
			if (hardReset || internalResetBit || !ctrl_q[i][BIT_OUT_ENABLE])
				out_q[i] <= 1'b0;
			else if (!ctrl_q[i][BIT_MEASURE_MODE] && ctrl_q[i][BIT_ONESHOT_POLARITY])
			begin
				if (counterLoadEvent[i])
					out_q[i] <= 1'b1;
				else if (timeOut[i])
					out_q[i] <= 1'b0;
			end
			else if (ctrl_q[i][BIT_BYTE_MODE])
				out_q[i] <= count_q[i][15:8] == BYTE_ZERO;
			else if (timeOut[i])
				out_q[i] <= ~out_q[i];
		end
	end

	assign timerOut = out_q;

	// Status and interrupt
	assign composite = |(flag_q & {ctrl_q[2][BIT_IRQ_MASK], ctrl_q[1][BIT_IRQ_MASK],
		ctrl_q[0][BIT_IRQ_MASK]});
	assign statusByte = {composite, STATUS_UNUSED, flag_q};
	assign irqOut = 1'b0;
	assign irqOeN = ~composite;

	// Read path
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			dataOut <= BYTE_ZERO;
			dataOeN <= 1'b1;
			lsbBuffer_q <= BYTE_ZERO;
		end
		else
		begin
			dataOeN <= ~(rd && regSelect != RS_CTRL13);
			if (statusRd)
				dataOut <= statusByte;
			else if (rd && isTimerCode(regSelect) && !regSelect[RS_ODD_POS])
			begin
				dataOut <= count_q[tmr][15:8];
				lsbBuffer_q <= count_q[tmr][7:0];
			end
			else if (rd && isTimerCode(regSelect))
				dataOut <= lsbBuffer_q;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	chk_status_unused: assert property (statusRd |=> dataOut[6:3] == STATUS_UNUSED)
		else $error("status unused bits not zero");
	chk_irq_composite: assert property (!irqOeN == (flag_q[2] && ctrl_q[2][BIT_IRQ_MASK]
		|| flag_q[1] && ctrl_q[1][BIT_IRQ_MASK] || flag_q[0] && ctrl_q[0][BIT_IRQ_MASK]))
		else $error("interrupt pin disagrees with masked flags");
	chk_reset_flags: assert property ((hardReset || internalResetBit) |=> flag_q == '0)
		else $error("flags survive a timer reset");
	chk_late_flag: assert property (counterRd[0] && flag_q[0] && !statusThenCounterRead_q[0]
		&& !latchWr[0] && !counterLoadEvent[0] |=> flag_q[0])
		else $error("unseen flag cleared by counter read");
	chk_seen_clear: assert property (statusRd && flag_q[0] ##2 counterRd[0] && !timeOut[0]
		&& !gateFall[0] && !gateRise[0] |=> !flag_q[0])
		else $error("seen flag not cleared by counter read");
	chk_latch_merge: assert property (latchWr[0] && !hardReset |=> latch_q[0]
		== {$past(holdByte_q), $past(dataIn)})
		else $error("latch write did not merge holding byte");
	chk_reset_latch: assert property (hardReset |=> latch_q[2] == LATCH_MAX)
		else $error("external reset did not preset latch");
	chk_intreset_latch: assert property (internalResetBit && !hardReset && latchWr == '0
		|=> $stable(latch_q[1]))
		else $error("internal reset disturbed a latch");
	chk_init_copy: assert property (counterLoadEvent[1] |=> count_q[1] == latch_q[1]
		&& !flag_q[1] || flag_q[1] && $past(gateFall[1]))
		else $error("counter load did not copy latch");
	chk_out_disabled: assert property (!ctrl_q[2][BIT_OUT_ENABLE] |=> !timerOut[2])
		else $error("disabled output went high");
	chk_bank_write: assert property (wr && regSelect == RS_CTRL13 && !hardReset
		&& ctrl_q[1][BIT_UNIQUE] |=> ctrl_q[0] == $past(dataIn))
		else $error("banked write missed control one");

	cov_timeout_flag: cover property (timeOut[0] ##1 flag_q[0]);
	cov_status_counter: cover property (statusRd && flag_q[0] ##[1:20] counterRd[0]);
	cov_byte_timeout: cover property (ctrl_q[1][BIT_BYTE_MODE] && timeOut[1]);
	cov_prescale: cover property (ctrl_q[2][BIT_UNIQUE] && timeOut[2]);
endmodule : ttc_timer_ctrl

// ---- test/ttc_cpu_model.sv ----
// Bus master model issuing single register accesses
`timescale 1ns/1ns
module ttc_cpu_model (
	input wire logic clock,
	input wire logic [7:0] dataOut,
	input wire logic dataOeN,
	output logic busEnable,
	output logic chipSelect0N,
	output logic chipSelect1,
	output logic readNotWrite,
	output logic [2:0] regSelect,
	output logic [7:0] dataIn
);
	initial
	begin
		busEnable = 1'b0;
		chipSelect0N = 1'b1;
		chipSelect1 = 1'b0;
		readNotWrite = 1'b1;
		regSelect = 3'h0;
		dataIn = 8'h5a;
	end

	// Released data lines show the inverse of the last value
	task automatic go(input logic sel, input logic rw, input logic [2:0] rs,
		input logic [7:0] d);
		@(posedge clock);
		busEnable <= sel;
		chipSelect0N <= ~sel;
		chipSelect1 <= sel;
		readNotWrite <= rw;
		regSelect <= rs;
		dataIn <= sel ? d : ~dataIn;
	endtask : go

	task automatic wr(input logic [2:0] rs, input logic [7:0] d);
		go(1'b1, 1'b0, rs, d);
		go(1'b0, 1'b0, rs, d);
	endtask : wr

	task automatic rd(input logic [2:0] rs, output logic [7:0] d, output logic oe);
		go(1'b1, 1'b1, rs, 8'h00);
		go(1'b0, 1'b1, rs, 8'h00);
		#1;
		d = dataOut;
		oe = dataOeN;
	endtask : rd
endmodule : ttc_cpu_model

// ---- test/ttc_timer_ctrl_tb_top.sv ----
// Self-checking bench for the triple timer control block
`timescale 1ns/1ns
module ttc_timer_ctrl_tb_top;
	import ttc_pkg::*;
	logic clock;
	logic sys_rst;
	logic extResetN;
	logic [2:0] gatePin;
	logic [2:0] clockPin;
	logic busEnable, chipSelect0N, chipSelect1, readNotWrite;
	logic [2:0] regSelect;
	logic [7:0] dataIn, dataOut, rdData;
	logic dataOeN, irqOut, irqOeN, irqIn, rdOe;
	logic [2:0] timerOut;
	int nFail = 0;
	int totalChecks = 0;
	int cyc = 0;
	int t0 = 0;

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock) cyc <= cyc + 1;

	// Pulled-up request line
	assign irqIn = irqOeN ? 1'b1 : irqOut;

	ttc_cpu_model CPU (
		.clock(clock),
		.dataOut(dataOut),
		.dataOeN(dataOeN),
		.busEnable(busEnable),
		.chipSelect0N(chipSelect0N),
		.chipSelect1(chipSelect1),
		.readNotWrite(readNotWrite),
		.regSelect(regSelect),
		.dataIn(dataIn)
	);

	ttc_timer_ctrl DUT (
		.clock(clock),
		.sys_rst(sys_rst),
		.busEnable(busEnable),
		.chipSelect0N(chipSelect0N),
		.chipSelect1(chipSelect1),
		.readNotWrite(readNotWrite),
		.regSelect(regSelect),
		.dataIn(dataIn),
		.dataOut(dataOut),
		.dataOeN(dataOeN),
		.irqIn(irqIn),
		.irqOut(irqOut),
		.irqOeN(irqOeN),
		.extResetN(extResetN),
		.clockPin(clockPin),
		.gatePin(gatePin),
		.timerOut(timerOut)
	);

	task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		totalChecks++;
		if (got !== exp)
		begin
			nFail++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk8

	task chk1(input logic got, input logic exp, input string what);
		totalChecks++;
		if (got !== exp)
		begin
			nFail++;
			$display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : chk1

	task rs(input logic [2:0] sel, input logic [7:0] exp);
		CPU.rd(sel, rdData, rdOe);
		chk8(rdData, exp, "read data");
		chk1(rdOe, 1'b0, "read drive");
	endtask : rs

	task wt(input int n);
		while (cyc - t0 < n)
			@(posedge clock);
	endtask : wt

	task final_report;
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (5000) @(posedge clock);
		nFail++;
		$display("mismatch at %0t: watchdog expired", $time);
		final_report;
	end

	initial
	begin
		sys_rst = 1'b1;
		extResetN = 1'b1;
		gatePin = 3'h0;
		clockPin = 3'h7;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
		rs(3'h1, 8'h00);
		CPU.rd(3'h0, rdData, rdOe);
		chk1(rdOe, 1'b1, "code 000 read");
		CPU.wr(3'h1, 8'h07);
		CPU.wr(3'h0, 8'h43);
		CPU.wr(3'h2, 8'h01);
		CPU.wr(3'h3, 8'h00);
		CPU.wr(3'h4, 8'h03);
		CPU.wr(3'h5, 8'h03);
		CPU.wr(3'h0, 8'h42);
		t0 = cyc;
		wt(10);
		rs(3'h1, 8'h00);
		wt(30);
		rs(3'h1, 8'h02);
		chk1(irqOeN, 1'b1, "masked request");
		CPU.wr(3'h5, 8'h03);
		rs(3'h1, 8'h00);
		CPU.wr(3'h1, 8'h01);
		$display("test byte mode and latch clear done");
		wt(240);
		rs(3'h1, 8'h00);
		wt(290);
		CPU.rd(3'h2, rdData, rdOe);
		rs(3'h1, 8'h81);
		chk1(irqOeN, 1'b0, "request");
		chk1(irqIn, 1'b0, "request line");
		CPU.rd(3'h2, rdData, rdOe);
		rs(3'h1, 8'h00);
		chk1(irqOeN, 1'b1, "request gone");
		$display("test word mode and read clear done");
		wt(560);
		rs(3'h1, 8'h81);
		CPU.wr(3'h0, 8'h43);
		rs(3'h1, 8'h00);
		rs(3'h2, 8'h01);
		rs(3'h3, 8'h00);
		$display("test internal reset done");
		@(posedge clock);
		extResetN <= 1'b0;
		repeat (5) @(posedge clock);
		extResetN <= 1'b1;
		repeat (5) @(posedge clock);
		rs(3'h2, 8'hff);
		rs(3'h3, 8'hff);
		rs(3'h1, 8'h00);
		CPU.wr(3'h6, 8'h12);
		CPU.wr(3'h3, 8'h34);
		rs(3'h2, 8'h12);
		rs(3'h3, 8'h34);
		$display("test external reset and holding byte done");
		CPU.wr(3'h0, 8'hc3);
		CPU.wr(3'h6, 8'h00);
		CPU.wr(3'h7, 8'h02);
		CPU.wr(3'h1, 8'h01);
		CPU.wr(3'h0, 8'h00);
		t0 = cyc;
		wt(10);
		rs(3'h1, 8'h00);
		chk1(timerOut[2], 1'b0, "timer three output early");
		wt(30);
		rs(3'h1, 8'h84);
		chk1(timerOut[2], 1'b1, "timer three output");
		$display("test prescaler done");
		CPU.wr(3'h1, 8'h1b);
		CPU.wr(3'h4, 8'h00);
		@(posedge clock);
		gatePin[1] <= 1'b1;
		repeat (5) @(posedge clock);
		rs(3'h1, 8'h86);
		CPU.wr(3'h5, 8'h0f);
		rs(3'h1, 8'h84);
		@(posedge clock);
		gatePin[1] <= 1'b0;
		repeat (5) @(posedge clock);
		gatePin[1] <= 1'b1;
		repeat (5) @(posedge clock);
		rs(3'h1, 8'h86);
		CPU.wr(3'h5, 8'h0f);
		@(posedge clock);
		gatePin[1] <= 1'b0;
		repeat (30) @(posedge clock);
		gatePin[1] <= 1'b1;
		repeat (5) @(posedge clock);
		rs(3'h1, 8'h84);
		$display("test pulse width comparison done");
		final_report;
	end
endmodule : ttc_timer_ctrl_tb_top
